// ==== verilog/sensor_frame_fifo_defs.svh ====
// register map, frame codes and sizes of the frame buffer
// assumes inclusion by the design file and the bench only
`ifndef SENSOR_FRAME_FIFO_DEFS_SVH
`define SENSOR_FRAME_FIFO_DEFS_SVH
`define OFS_CTRL    8'h00
`define OFS_LEN_LO  8'h04
`define OFS_LEN_HI  8'h08
`define OFS_DATA    8'h0C
`define OFS_STATUS  8'h10
`define CTRL_W      10
`define CTRL_RESET  10'h000
`define BUF_BYTES   10'd512
`define FRAME_MAX   10'd9
`define FT_SENSOR   2'b10
`define FT_CTRL     2'b01
`define SEL_FILT    2'b01
`define HDR_EMPTY   8'h80
`define HDR_TIME    8'hA0
`define HDR_ERR     8'h44
`define OPC_ERR     8'h01
`define HDR_CHG     8'h48
`define OPC_CHG     8'h02
`define LEN_CTRL    4'd2
`define LEN_TIME    3'd4
`define LEN_EMPTY   3'd2
`endif

// ==== verilog/sensor_frame_fifo_pkg.sv ====
// types shared by the frame buffer and its bench
// assumes the defs header sits beside it
package sensor_frame_fifo_pkg;
	// writer sequencing
	typedef enum logic [1:0] {
		W_IDLE  = 2'b00,
		W_CHECK = 2'b01,
		W_EVICT = 2'b10,
		W_WRITE = 2'b11
	} wr_state_type;
	// one measurement result, raw and filtered
	typedef struct packed {
		logic [23:0] press_raw;
		logic [23:0] press_filt;
		logic [23:0] temp_raw;
		logic [23:0] temp_filt;
	} meas_type;
	// control register layout, bit 0 is mode
	typedef struct packed {
		logic [2:0] subs;
		logic [1:0] sel;
		logic       stop;
		logic       time_en;
		logic       temp_en;
		logic       press_en;
		logic       mode;
	} ctrl_type;
endpackage

// ==== verilog/sensor_frame_fifo.sv ====
// frame-oriented measurement buffer with an AHB-Lite register slave
// assumes one clock, measurement engine pulses meas_valid once per result
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "sensor_frame_fifo_defs.svh"

module sensor_frame_fifo
	import sensor_frame_fifo_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        meas_valid,
	input  wire meas_type    meas,
	input  wire logic        normal_mode,
	input  wire logic        cfg_change,
	input  wire logic        cfg_error,
	input  wire logic [23:0] sensor_time
);
	logic [7:0]   mem_ff [0:511];
	ctrl_type     ctrl_ff;
	wr_state_type wstate_ff;
	logic [9:0]   count_ff;
	logic [8:0]   rd_base_ff;
	logic [3:0]   rd_off_ff;
	logic [7:0]   stage_ff [0:6];
	logic [3:0]   stage_len_ff;
	logic [3:0]   wr_idx_ff;
	logic         sens_pend_ff;
	logic         chg_pend_ff;
	logic         err_pend_ff;
	logic [6:0]   subs_cnt_ff;
	logic         normal_prev_ff;
	logic [2:0]   tail_idx_ff;
	logic         tail_kind_ff;
	logic         time_sent_ff;
	logic [23:0]  time_cap_ff;
	logic         wr_pend_ff;
	logic [7:0]   wr_addr_ff;
	logic [31:0]  hrdata_ff;
	meas_type     meas_ff;
	logic         meas_t_ff;
	logic         meas_p_ff;
	logic         access;
	logic         pop;
	logic         burst_end;
	logic         enabled;
	logic         rise;
	logic         accept_meas;
	logic [9:0]   free;
	logic         full;
	logic         fits;
	logic [7:0]   cur_hdr;
	logic [3:0]   cur_len;
	logic         from_store;
	logic         consume;
	logic         evict_now;
	logic         commit;
	logic         tail_time;
	logic [7:0]   out_byte;
	logic [31:0]  rdata_nxt;
	logic [9:0]   nxt_count;
	logic [23:0]  tv;
	logic [23:0]  pv;
	logic [7:0]   sens_hdr;
	logic [8:0]   wr_pos;
	// bytes a frame spans, from its header
	function automatic logic [3:0] frame_len(input logic [7:0] h);
		if (h[7:6] != `FT_SENSOR)
			return `LEN_CTRL;
		if (!h[4] && !h[2])
			return 4'd2;
		return 4'd1 + (h[4] ? 4'd3 : 4'd0) + (h[2] ? 4'd3 : 4'd0);
	endfunction

	// bus decode; slave never waits
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;
	assign access    = hsel && hready && htrans[1];
	assign pop       = access && !hwrite && (haddr[7:0] == `OFS_DATA);
	assign burst_end = access && !pop;

	// writer side conditions
	assign enabled   = ctrl_ff.mode && (ctrl_ff.press_en || ctrl_ff.temp_en);
	assign rise      = normal_mode && !normal_prev_ff;
	assign accept_meas = meas_valid && enabled &&
		(!normal_mode || rise || subs_cnt_ff == 7'h00);
	assign free      = `BUF_BYTES - count_ff;
	assign full      = free < `FRAME_MAX;
	assign fits      = free >= {6'h00, stage_len_ff};

	// reader side: oldest frame sits at rd_base
	assign cur_hdr    = mem_ff[rd_base_ff];
	assign cur_len    = frame_len(cur_hdr);
	assign from_store = (count_ff != 10'h000) && (tail_idx_ff == 3'd0);
	assign consume    = pop && from_store && (rd_off_ff + 4'd1 == cur_len);
	assign evict_now  = (wstate_ff == W_EVICT) && !fits && !consume;
	assign commit     = (wstate_ff == W_WRITE) && (wr_idx_ff + 4'd1 == stage_len_ff);
	assign tail_time  = ctrl_ff.time_en && !time_sent_ff;
	assign wr_pos     = rd_base_ff + count_ff[8:0] + {5'h00, wr_idx_ff};

	// byte handed out on a data read
	always_comb begin
		out_byte = `HDR_EMPTY;
		if (from_store) begin
			out_byte = mem_ff[rd_base_ff + {5'h00, rd_off_ff}];
		end else if (tail_idx_ff == 3'd0) begin
			out_byte = tail_time ? `HDR_TIME : `HDR_EMPTY;
		end else if (tail_kind_ff) begin
			case (tail_idx_ff)
				3'd1:    out_byte = time_cap_ff[7:0];
				3'd2:    out_byte = time_cap_ff[15:8];
				default: out_byte = time_cap_ff[23:16];
			endcase
		end else begin
			out_byte = 8'h00;
		end
	end

	// register read mux, unmapped reads as zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (haddr[7:0])
			`OFS_CTRL:   rdata_nxt = {22'h000000, ctrl_ff};
			`OFS_LEN_LO: rdata_nxt = {24'h000000, count_ff[7:0]};
			`OFS_LEN_HI: rdata_nxt = {31'h00000000, count_ff[8]};
			`OFS_DATA:   rdata_nxt = {24'h000000, out_byte};
			`OFS_STATUS: rdata_nxt = {29'h00000000, wstate_ff != W_IDLE, full,
				count_ff == 10'h000};
			default:     rdata_nxt = 32'h0000_0000;
		endcase
	end

	// read data registered at the address phase
	always_ff @(posedge clock) begin
		if (!resetn)
			hrdata_ff <= 32'h0000_0000;
		else if (access && !hwrite)
			hrdata_ff <= rdata_nxt;
	end

	// write address phase held for the data phase
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= access && hwrite;
			wr_addr_ff <= haddr[7:0];
		end
	end

	// control register
	always_ff @(posedge clock) begin
		if (!resetn)
			ctrl_ff <= `CTRL_RESET;
		else if (wr_pend_ff && wr_addr_ff == `OFS_CTRL)
			ctrl_ff <= hwdata[`CTRL_W-1:0];
	end

	// down-sampling counter on the measurement grid
	always_ff @(posedge clock) begin
		if (!resetn) begin
			subs_cnt_ff    <= 7'h00;
			normal_prev_ff <= 1'b0;
		end else begin
			normal_prev_ff <= normal_mode;
			if (rise && !meas_valid)
				subs_cnt_ff <= 7'h00;
			else if (meas_valid && normal_mode)
				subs_cnt_ff <= (rise ? 7'h01 : subs_cnt_ff + 7'h01) &
					((7'h01 << ctrl_ff.subs) - 7'h01);
		end
	end

	// pending frame requests; a new event wins over its clear
	always_ff @(posedge clock) begin
		if (!resetn) begin
			sens_pend_ff <= 1'b0;
			chg_pend_ff  <= 1'b0;
			err_pend_ff  <= 1'b0;
			meas_ff      <= '0;
			meas_t_ff    <= 1'b0;
			meas_p_ff    <= 1'b0;
		end else begin
			if (accept_meas) begin
				sens_pend_ff <= 1'b1;
				meas_ff      <= meas;
				meas_t_ff    <= ctrl_ff.temp_en;
				meas_p_ff    <= ctrl_ff.press_en;
			end else if (!enabled || (wstate_ff == W_IDLE && !err_pend_ff && !chg_pend_ff)) begin
				sens_pend_ff <= 1'b0;
			end
			if ((cfg_change || (wr_pend_ff && wr_addr_ff == `OFS_CTRL)) &&
				normal_mode && enabled)
				chg_pend_ff <= 1'b1;
			else if (wstate_ff == W_IDLE && sens_pend_ff && !err_pend_ff && enabled)
				chg_pend_ff <= 1'b0;
			if (cfg_error)
				err_pend_ff <= 1'b1;
			else if (wstate_ff == W_IDLE && enabled)
				err_pend_ff <= 1'b0;
		end
	end

	// sensor frame contents
	assign tv       = (ctrl_ff.sel == `SEL_FILT) ? meas_ff.temp_filt : meas_ff.temp_raw;
	assign pv       = (ctrl_ff.sel == `SEL_FILT) ? meas_ff.press_filt : meas_ff.press_raw;
	assign sens_hdr = {`FT_SENSOR, 1'b0, meas_t_ff, 1'b0, meas_p_ff, 2'b00};

	// writer sequence: stage, check room, evict, write bytes
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wstate_ff    <= W_IDLE;
			stage_len_ff <= 4'd0;
			wr_idx_ff    <= 4'd0;
			for (int i = 0; i < 7; i++)
				stage_ff[i] <= 8'h00;
		end else begin
			case (wstate_ff)
				W_IDLE: begin
					wr_idx_ff <= 4'd0;
					if (enabled && err_pend_ff) begin
						stage_ff[0]  <= `HDR_ERR;
						stage_ff[1]  <= `OPC_ERR;
						stage_len_ff <= `LEN_CTRL;
						wstate_ff    <= W_CHECK;
					end else if (enabled && sens_pend_ff && chg_pend_ff) begin
						stage_ff[0]  <= `HDR_CHG;
						stage_ff[1]  <= `OPC_CHG;
						stage_len_ff <= `LEN_CTRL;
						wstate_ff    <= W_CHECK;
					end else if (enabled && sens_pend_ff) begin
						stage_ff[0]  <= sens_hdr;
						stage_ff[1]  <= meas_t_ff ? tv[7:0] : pv[7:0];
						stage_ff[2]  <= meas_t_ff ? tv[15:8] : pv[15:8];
						stage_ff[3]  <= meas_t_ff ? tv[23:16] : pv[23:16];
						stage_ff[4]  <= pv[7:0];
						stage_ff[5]  <= pv[15:8];
						stage_ff[6]  <= pv[23:16];
						stage_len_ff <= frame_len(sens_hdr);
						wstate_ff    <= W_CHECK;
					end
				end
				W_CHECK: begin
					if (full && ctrl_ff.stop)
						wstate_ff <= W_IDLE;
					else if (!fits)
						wstate_ff <= W_EVICT;
					else
						wstate_ff <= W_WRITE;
				end
				W_EVICT: begin
					if (fits)
						wstate_ff <= W_WRITE;
				end
				W_WRITE: begin
					wr_idx_ff <= wr_idx_ff + 4'd1;
					if (commit)
						wstate_ff <= W_IDLE;
				end
				default: wstate_ff <= W_IDLE;
			endcase
		end
	end

	// frame storage, written behind the committed region
	always_ff @(posedge clock) begin
		if (wstate_ff == W_WRITE)
			mem_ff[wr_pos] <= stage_ff[wr_idx_ff[2:0]];
	end

	// byte count and oldest-frame pointer, whole frames only
	always_comb begin
		nxt_count = count_ff;
		if (commit)
			nxt_count = nxt_count + {6'h00, stage_len_ff};
		if (consume || evict_now)
			nxt_count = nxt_count - {6'h00, cur_len};
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			count_ff   <= 10'h000;
			rd_base_ff <= 9'h000;
		end else begin
			count_ff <= nxt_count;
			if (consume || evict_now)
				rd_base_ff <= rd_base_ff + {5'h00, cur_len};
		end
	end

	// read offset inside the oldest frame
	always_ff @(posedge clock) begin
		if (!resetn)
			rd_off_ff <= 4'd0;
		else if (burst_end || consume || evict_now)
			rd_off_ff <= 4'd0;
		else if (pop && from_store)
			rd_off_ff <= rd_off_ff + 4'd1;
	end

	// trailing sensortime and empty frames of a burst
	always_ff @(posedge clock) begin
		if (!resetn) begin
			tail_idx_ff  <= 3'd0;
			tail_kind_ff <= 1'b0;
			time_sent_ff <= 1'b0;
			time_cap_ff  <= 24'h000000;
		end else if (burst_end) begin
			tail_idx_ff  <= 3'd0;
			time_sent_ff <= 1'b0;
		end else if (pop && !from_store) begin
			if (tail_idx_ff == 3'd0) begin
				tail_kind_ff <= tail_time;
				tail_idx_ff  <= 3'd1;
				if (tail_time) begin
					time_cap_ff  <= sensor_time;
					time_sent_ff <= 1'b1;
				end
			end else if (tail_idx_ff + 3'd1 == (tail_kind_ff ? `LEN_TIME : `LEN_EMPTY)) begin
				tail_idx_ff <= 3'd0;
			end else begin
				tail_idx_ff <= tail_idx_ff + 3'd1;
			end
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_time_start;
		pop && from_store == 1'b0 && tail_idx_ff == 3'd0 && tail_time;
	endsequence
	sequence s_empty_start;
		pop && !from_store && tail_idx_ff == 3'd0 && !tail_time;
	endsequence
	chk_count_hold: assert property (!commit && !consume && !evict_now |=>
		count_ff == $past(count_ff))
		else $error("byte count moved without a whole frame");
	chk_count_limit: assert property (count_ff <= `BUF_BYTES)
		else $error("byte count above storage size");
	chk_full_drop: assert property (wstate_ff == W_CHECK && full && ctrl_ff.stop |=>
		wstate_ff == W_IDLE)
		else $error("stop-on-full did not drop the frame");
	chk_evict_mode: assert property (wstate_ff == W_EVICT |-> !ctrl_ff.stop)
		else $error("eviction in stop-on-full mode");
	chk_write_room: assert property (wstate_ff == W_WRITE && wr_idx_ff == 4'd0 |-> fits)
		else $error("frame written without room");
	chk_time_frame: assert property (s_time_start |=> hrdata_ff[7:0] == `HDR_TIME
		##1 tail_idx_ff != 3'd0 || !pop)
		else $error("sensortime header missing");
	chk_empty_frame: assert property (s_empty_start |=> hrdata_ff[7:0] == `HDR_EMPTY)
		else $error("empty frame header wrong");
	chk_subs_skip: assert property (meas_valid && normal_mode && !rise &&
		subs_cnt_ff != 7'h00 |-> !accept_meas)
		else $error("result stored inside a down-sampling period");
	chk_err_stage: assert property (wstate_ff == W_IDLE && enabled && err_pend_ff |=>
		stage_ff[0] == `HDR_ERR && stage_ff[1] == `OPC_ERR && wstate_ff == W_CHECK)
		else $error("error frame not staged");
	chk_partial_rewind: assert property (burst_end |=> rd_off_ff == 4'd0)
		else $error("partial frame not rewound");
endmodule // sensor_frame_fifo

// ==== test/ahb_host_model.sv ====
// host model: single-word AHB-Lite master reading the frame buffer
// assumes the bench calls xfer after reset and provides hang for stuck waits
`timescale 1ns/1ps

module ahb_host_model (
	input  wire logic        clock,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// idle bus until the first transfer
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// bounded wait for hready sampled high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) sensor_frame_fifo_bench.hang();
	endtask

	// one single transfer; address phase, then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a}; // data address reads back to back drain
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= w ? wd : ~hwdata; // no stale data on reads
		wait_ready();
		rd = hrdata;
	endtask
endmodule // ahb_host_model

// ==== test/sensor_frame_fifo_bench.sv ====
// bench for the frame buffer: engine stimulus, host reads, self-checks
// assumes the package, defs header and host model are compiled first
`timescale 1ns/1ps
`include "sensor_frame_fifo_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end

module sensor_frame_fifo_bench
	import sensor_frame_fifo_pkg::*;
;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        meas_valid = 1'b0;
	meas_type    meas = '0;
	logic        normal_mode = 1'b0;
	logic        cfg_change = 1'b0;
	logic        cfg_error = 1'b0;
	logic [23:0] sensor_time = 24'h123456;
	int          n_fail = 0;
	int          checked = 0;
	logic [31:0] rd;
	logic [23:0] tv;
	logic [23:0] pv;
	logic [7:0]  q[$];
	logic [9:0]  r_ctrl [6] = '{10'h007, 10'h003, 10'h005, 10'h027, 10'h047, 10'h067};
	logic [7:0]  r_hdr [6] = '{8'h94, 8'h84, 8'h90, 8'h94, 8'h94, 8'h94};
	logic [7:0]  st [10] = '{8'h84, 8'h11, 8'h22, 8'h33, 8'hA0, 8'h56, 8'h34, 8'h12,
		8'h80, 8'h00};

	always #20 clock = ~clock;

	sensor_frame_fifo u_dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.meas_valid(meas_valid), .meas(meas), .normal_mode(normal_mode),
		.cfg_change(cfg_change), .cfg_error(cfg_error), .sensor_time(sensor_time));

	ahb_host_model u_host (.clock(clock), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));

	// counts, verdict, end of run
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic hang;
		n_fail++;
		end_sim();
	endtask

	task automatic rdr(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, rd);
	endtask

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd);
	endtask

	// one result on the measurement grid, spaced for the writer
	task automatic push(input logic [7:0] b);
		meas <= '{press_raw: 24'h332211, press_filt: 24'h665544,
			temp_raw: {16'h9988, b}, temp_filt: 24'hCCBBAA};
		meas_valid <= 1'b1;
		@(posedge clock);
		meas_valid <= 1'b0;
		repeat (30) @(posedge clock);
	endtask

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
	endtask

	task automatic count_is(input logic [8:0] c);
		rdr(`OFS_LEN_LO);
		`CHK(rd[7:0], c[7:0])
		rdr(`OFS_LEN_HI);
		`CHK(rd[0], c[8])
	endtask

	// main sequence
	initial begin
		do_reset();
		rdr(`OFS_CTRL);
		`CHK(rd, 32'h0)
		`CHK(hresp, 1'b0)
		count_is(9'd0);
		$display("reset test done");
		// table rows: store enables and data select
		for (int i = 0; i < 6; i++) begin
			tv = (r_ctrl[i][6:5] == 2'b01) ? 24'hCCBBAA : 24'h998877;
			pv = (r_ctrl[i][6:5] == 2'b01) ? 24'h665544 : 24'h332211;
			q = {};
			if (r_ctrl[i][2]) q = {tv[7:0], tv[15:8], tv[23:16]};
			if (r_ctrl[i][1]) q = {q, pv[7:0], pv[15:8], pv[23:16]};
			wrr(`OFS_CTRL, {22'h0, r_ctrl[i]});
			push(8'h77);
			count_is(9'(q.size() + 1));
			rdr(`OFS_DATA);
			`CHK(rd[7:0], r_hdr[i])
			count_is(9'(q.size() + 1));
			rdr(`OFS_DATA);
			`CHK(rd[7:0], r_hdr[i])
			foreach (q[k]) begin
				rdr(`OFS_DATA);
				`CHK(rd[7:0], q[k])
			end
			rdr(`OFS_DATA);
			`CHK(rd[7:0], 8'h80)
			rdr(`OFS_DATA);
			`CHK(rd[7:0], 8'h00)
			count_is(9'd0);
		end
		$display("row test done");
		// configuration error frame
		wrr(`OFS_CTRL, 32'h003);
		cfg_error <= 1'b1;
		@(posedge clock);
		cfg_error <= 1'b0;
		repeat (30) @(posedge clock);
		count_is(9'd2);
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h44)
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h01)
		// sensortime appended after stored data, then empty frames
		wrr(`OFS_CTRL, 32'h00B);
		push(8'h77);
		foreach (st[k]) begin
			rdr(`OFS_DATA);
			`CHK(rd[7:0], st[k])
		end
		count_is(9'd0);
		$display("control and time test done");
		// streaming overflow evicts the oldest frames
		do_reset();
		wrr(`OFS_CTRL, 32'h007);
		for (int i = 0; i < 80; i++) push(i[7:0]);
		rdr(`OFS_LEN_HI);
		`CHK(rd[0], 1'b1)
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h94)
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h07)
		$display("streaming test done");
		// stop-on-full keeps the oldest 72 frames and resumes later
		do_reset();
		wrr(`OFS_CTRL, 32'h017);
		for (int i = 0; i < 80; i++) push(i[7:0]);
		count_is(9'd504);
		rdr(`OFS_STATUS);
		`CHK(rd, 32'h0000_0002)
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h94)
		for (int k = 0; k < 6; k++) begin
			rdr(`OFS_DATA);
			if (k == 0) `CHK(rd[7:0], 8'h00)
		end
		count_is(9'd497);
		push(8'hEE);
		count_is(9'd504);
		$display("stop test done");
		// down-sampling by 4 in normal mode, change frame, disable
		do_reset();
		wrr(`OFS_CTRL, 32'h103);
		normal_mode <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 8; i++) push(8'h01);
		count_is(9'd8);
		cfg_change <= 1'b1;
		@(posedge clock);
		cfg_change <= 1'b0;
		for (int i = 0; i < 4; i++) push(8'h02);
		count_is(9'd14);
		wrr(`OFS_CTRL, 32'h102);
		for (int i = 0; i < 4; i++) push(8'h03);
		count_is(9'd14);
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h84)
		// skip the rest of two sensor frames to reach the change frame
		for (int k = 0; k < 7; k++) begin
			rdr(`OFS_DATA);
		end
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h48)
		rdr(`OFS_DATA);
		`CHK(rd[7:0], 8'h02)
		normal_mode <= 1'b0;
		$display("down-sampling test done");
		end_sim();
	end
endmodule // sensor_frame_fifo_bench
